/* xor_extract_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module xor_extract_unit
    import xor_extract_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic issue_in,
    input wire instr_t instr_in,
    input wire logic exec_mode_bit_in,
    input wire logic [WORD_W-1:0] mem_rdata_in,
    input wire logic mem_rvalid_in,
    output logic busy_out,
    output mem_req_t mem_req_out,
    output logic [NREGS-1:0] limit_tag_bit_out,
    output logic [DATA_W-1:0] dest_value_out
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] data_q [NREGS];
    logic [DATA_W-1:0] data_d [NREGS];
    logic [ADDR_W-1:0] addr_q [NREGS];
    logic [ADDR_W-1:0] addr_d [NREGS];
    logic [NREGS-1:0] limit_q;
    logic [NREGS-1:0] limit_d;
    logic [ADDR_W-1:0] sp_norm_q;
    logic [ADDR_W-1:0] sp_exc_q;
    logic [DATA_W-1:0] dest_val_q;
    logic [DATA_W-1:0] dest_val_d;

    // selections; prefix adds the upper bank
    logic [3:0] dest_d_idx;
    logic [3:0] src_d_idx;
    logic [3:0] fld_d_idx;
    logic [3:0] dr_idx;
    logic dr_is_addr;
    assign dest_d_idx = {instr_in.high_prefix, instr_in.dest_sel[2:0]};
    assign src_d_idx = {instr_in.high_prefix, instr_in.src_sel};
    assign fld_d_idx = {instr_in.high_prefix, instr_in.field_src};
    assign dr_is_addr = instr_in.dest_sel >= ADDR_SEL_BASE;
    assign dr_idx = {instr_in.high_prefix, instr_in.dest_sel[2:0]};

    // extraction operands
    logic [FIELD_W-1:0] ex_width;
    logic [FIELD_W-1:0] ex_offset;
    logic [DATA_W-1:0] ex_result;
    always_comb
    begin
        if (instr_in.op == OP_EXTRACT_REG)
        begin
            ex_width = data_q[src_d_idx][WIDTH_POS +: FIELD_W];
            ex_offset = data_q[src_d_idx][OFFSET_POS +: FIELD_W];
        end
        else
        begin
            ex_width = instr_in.width_imm;
            ex_offset = instr_in.offset_imm;
        end
    end

    field_extract #(.W(DATA_W)) u_extract (
        .src_in(data_q[fld_d_idx]),
        .width_in(ex_width),
        .offset_in(ex_offset),
        .result_out(ex_result)
    );

    // ----------------------------------------------------------------
    // memory read-modify-write sequencer
    // ----------------------------------------------------------------
    rmw_state_t state_q;
    rmw_state_t state_d;
    mem_req_t req_q;
    mem_req_t req_d;
    logic [WORD_W-1:0] imm_q;
    logic [WORD_W-1:0] imm_d;
    logic [ADDR_W-1:0] active_sp;
    logic [ADDR_W-1:0] ea;
    logic start_mem;

    assign active_sp = exec_mode_bit_in ? sp_exc_q : sp_norm_q;
    assign start_mem = issue_in && state_q == ST_IDLE &&
        (instr_in.op inside {OP_XOR_MEM_REG, OP_XOR_MEM_SPM,
                             OP_XOR_MEM_SPP, OP_XOR_MEM_ABS});

    // effective address; alignment is the program's duty
    always_comb
    begin
        case (instr_in.op)
            OP_XOR_MEM_SPM:
                ea = active_sp - {26'h0, instr_in.offset[5:1], 1'b0};
            OP_XOR_MEM_SPP:
                ea = active_sp + {{16{instr_in.offset[15]}},
                                  instr_in.offset};
            OP_XOR_MEM_ABS:
                ea = {16'h0000, instr_in.offset};
            default:
                ea = addr_q[{instr_in.high_prefix, instr_in.dest_sel[2:0]}];
        endcase
    end

    // read first, write only after data returns, same address
    always_comb
    begin
        state_d = state_q;
        req_d = req_q;
        imm_d = imm_q;
        req_d.rd = 1'b0;
        req_d.wr = 1'b0;
        case (state_q)
            ST_IDLE:
                if (start_mem)
                begin
                    req_d.rd = 1'b1;
                    req_d.addr = ea;
                    imm_d = instr_in.imm;
                    state_d = ST_READ;
                end
            ST_READ:
                if (mem_rvalid_in)
                begin
                    req_d.wr = 1'b1;
                    req_d.wdata = mem_rdata_in ^ imm_q;
                    state_d = ST_WRITE;
                end
            ST_WRITE:
                state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            state_q <= ST_IDLE;
            req_q <= '0;
            imm_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            req_q <= req_d;
            imm_q <= imm_d;
        end
    end

    // ----------------------------------------------------------------
    // register writeback
    // ----------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < NREGS; i++)
        begin
            data_d[i] = data_q[i];
            addr_d[i] = addr_q[i];
        end
        limit_d = limit_q;
        dest_val_d = dest_val_q;
        if (issue_in && state_q == ST_IDLE)
        begin
            case (instr_in.op)
                OP_XOR_REG:
                begin
                    data_d[dest_d_idx] = data_q[src_d_idx] ^
                                         data_q[dest_d_idx];
                    limit_d[dest_d_idx] = 1'b0;
                    dest_val_d = data_d[dest_d_idx];
                end
                OP_XOR_LOW, OP_XOR_HIGH:
                    if (dr_is_addr)
                    begin
                        if (instr_in.op == OP_XOR_LOW)
                            addr_d[dr_idx][HALF_LO +: WORD_W] =
                                addr_q[dr_idx][HALF_LO +: WORD_W] ^
                                instr_in.imm;
                        else
                            addr_d[dr_idx][HALF_HI +: WORD_W] =
                                addr_q[dr_idx][HALF_HI +: WORD_W] ^
                                instr_in.imm;
                        dest_val_d = {8'h00, addr_d[dr_idx]};
                    end
                    else
                    begin
                        if (instr_in.op == OP_XOR_LOW)
                            data_d[dr_idx][HALF_LO +: WORD_W] =
                                data_q[dr_idx][HALF_LO +: WORD_W] ^
                                instr_in.imm;
                        else
                            data_d[dr_idx][HALF_HI +: WORD_W] =
                                data_q[dr_idx][HALF_HI +: WORD_W] ^
                                instr_in.imm;
                        limit_d[dr_idx] = 1'b0;
                        dest_val_d = data_d[dr_idx];
                    end
                OP_EXTRACT_IMM, OP_EXTRACT_REG:
                begin
                    data_d[dest_d_idx] = ex_result;
                    limit_d[dest_d_idx] = 1'b0;
                    dest_val_d = ex_result;
                end
                default:
                    dest_val_d = dest_val_q;
            endcase
        end
    end

    // registers reset to zero; limit tags start clear
    always_ff @(posedge ref_clk_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            for (int i = 0; i < NREGS; i++)
            begin
                data_q[i] <= DATA_RESET;
                addr_q[i] <= ADDR_RESET;
            end
            limit_q <= '0;
            sp_norm_q <= SP_RESET;
            sp_exc_q <= SP_RESET;
            dest_val_q <= DATA_RESET;
        end
        else
        begin
            for (int i = 0; i < NREGS; i++)
            begin
                data_q[i] <= data_d[i];
                addr_q[i] <= addr_d[i];
            end
            limit_q <= limit_d;
            sp_norm_q <= sp_norm_q;
            sp_exc_q <= sp_exc_q;
            dest_val_q <= dest_val_d;
        end
    end

    // ----------------------------------------------------------------
    // checker helper: address of the last read
    // ----------------------------------------------------------------
    // kept apart from req_q so that a broken address hold would show
    logic [ADDR_W-1:0] rd_addr_q;
    logic [ADDR_W-1:0] rd_addr_d;

    always_comb
    begin
        rd_addr_d = rd_addr_q;
        if (req_q.rd)
            rd_addr_d = req_q.addr;
    end

    always_ff @(posedge ref_clk_in or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
            rd_addr_q <= '0;
        else
            rd_addr_q <= rd_addr_d;
    end

    assign busy_out = state_q != ST_IDLE;
    assign mem_req_out = req_q;
    assign limit_tag_bit_out = limit_q;
    assign dest_value_out = dest_val_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_read_issued;
        mem_req_out.rd;
    endsequence

    a_rmw_write_after_read: assert property (
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        mem_req_out.wr |-> $past(state_q) == ST_READ && $past(mem_rvalid_in))
        else $error("write issued without returned read data");

    a_rmw_same_addr: assert property (
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        mem_req_out.wr |-> mem_req_out.addr == rd_addr_q)
        else $error("rmw write address differs from read");

    a_read_while_busy: assert property (
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        s_read_issued |-> busy_out && !mem_req_out.wr)
        else $error("read issued outside a busy rmw");

    a_rmw_wdata: assert property (
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        mem_req_out.wr |-> mem_req_out.wdata == ($past(mem_rdata_in) ^ imm_q))
        else $error("rmw write data is not read xor immediate");

    a_rmw_single_write: assert property (
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        mem_req_out.wr |=> !mem_req_out.wr && !mem_req_out.rd)
        else $error("more than two accesses per rmw");

    a_xor_reg_result: assert property (
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        issue_in && state_q == ST_IDLE && instr_in.op == OP_XOR_REG &&
        src_d_idx != dest_d_idx
        |=> dest_value_out == ($past(data_q[src_d_idx]) ^
                               $past(data_q[dest_d_idx])))
        else $error("register xor result wrong");

    a_limit_clear: assert property (
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        issue_in && state_q == ST_IDLE &&
        instr_in.op inside {OP_XOR_REG, OP_EXTRACT_IMM, OP_EXTRACT_REG}
        |=> !limit_tag_bit_out[$past(dest_d_idx)])
        else $error("limit tag not cleared");

    a_low_half_keep: assert property (
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        issue_in && state_q == ST_IDLE && instr_in.op == OP_XOR_LOW &&
        !dr_is_addr
        |=> dest_value_out[DATA_W-1:HALF_HI] ==
            $past(data_q[dr_idx][DATA_W-1:HALF_HI]))
        else $error("low-half xor disturbed upper bits");

    a_extract_sign: assert property (
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        issue_in && state_q == ST_IDLE && instr_in.op == OP_EXTRACT_IMM &&
        instr_in.width_imm != '0
        |=> dest_value_out[SIGN_TOP] ==
            dest_value_out[$past(instr_in.width_imm) - 6'h01])
        else $error("extracted field not sign-extended");
endmodule : xor_extract_unit
`default_nettype wire

/* xor_extract_pkg.sv */
package xor_extract_pkg;

    // ----------------------------------------------------------------
    // widths and register file shape
    // ----------------------------------------------------------------
    localparam int DATA_W = 40;
    localparam int ADDR_W = 32;
    localparam int WORD_W = 16;
    localparam int SEL_W = 4;
    localparam int FIELD_W = 6;
    localparam int NREGS = 16;
    localparam int HALF_LO = 0;
    localparam int HALF_HI = 16;
    localparam int WIDTH_POS = 8;
    localparam int OFFSET_POS = 0;
    localparam int SIGN_TOP = 39;
    localparam logic [SEL_W-1:0] ADDR_SEL_BASE = 4'h8;
    localparam logic [DATA_W-1:0] DATA_RESET = 40'h00_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [ADDR_W-1:0] SP_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // operations
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_XOR_REG = 4'h1,
        OP_XOR_LOW = 4'h2,
        OP_XOR_HIGH = 4'h3,
        OP_XOR_MEM_REG = 4'h4,
        OP_XOR_MEM_SPM = 4'h5,
        OP_XOR_MEM_SPP = 4'h6,
        OP_XOR_MEM_ABS = 4'h7,
        OP_EXTRACT_IMM = 4'h8,
        OP_EXTRACT_REG = 4'h9
    } op_t;

    typedef struct packed {
        op_t op;
        logic high_prefix;
        logic [SEL_W-1:0] dest_sel;
        logic [2:0] src_sel;
        logic [2:0] field_src;
        logic [WORD_W-1:0] imm;
        logic [WORD_W-1:0] offset;
        logic [FIELD_W-1:0] width_imm;
        logic [FIELD_W-1:0] offset_imm;
    } instr_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } mem_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } rmw_state_t;

endpackage : xor_extract_pkg

/* field_extract.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// signed field extraction, purely combinational
// ----------------------------------------------------------------
module field_extract
    import xor_extract_pkg::*;
#(
    parameter int W = DATA_W
)
(
    input wire logic [W-1:0] src_in,
    input wire logic [FIELD_W-1:0] width_in,
    input wire logic [FIELD_W-1:0] offset_in,
    output logic [W-1:0] result_out
);
    logic [W-1:0] shifted;
    logic [W-1:0] mask;
    logic sign;

    // shift down, mask to width, replicate the field's top bit upward
    always_comb
    begin
        shifted = src_in >> offset_in;
        mask = (width_in == '0) ? '0 : ({W{1'b1}} >> (W - int'(width_in)));
        sign = (width_in == '0) ? 1'b0 : shifted[width_in - 6'h01];
        result_out = (shifted & mask) | (sign ? ~mask : '0);
    end
endmodule : field_extract
`default_nettype wire

/* rmw_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// data memory seen by the read-modify-write port
// ----------------------------------------------------------------
module rmw_mem_model
    import xor_extract_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire mem_req_t req_in,
    input wire logic slow_in,
    output logic [WORD_W-1:0] rdata_out,
    output logic rvalid_out
);
    logic [WORD_W-1:0] store [logic [ADDR_W-1:0]];
    logic [ADDR_W-1:0] addr_q;
    logic pend_q;
    int wait_q;

    // one word per read, answered promptly or after four idle cycles;
    // between answers the data lines churn so stale data never matches
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pend_q <= 1'b0;
            wait_q <= 0;
            rvalid_out <= 1'b0;
            rdata_out <= 16'h0f0f;
        end
        else
        begin
            rvalid_out <= 1'b0;
            rdata_out <= ~rdata_out;
            if (req_in.rd)
            begin
                pend_q <= 1'b1;
                addr_q <= req_in.addr;
                wait_q <= slow_in ? 4 : 0;
            end
            else if (pend_q && wait_q > 0)
                wait_q <= wait_q - 1;
            else if (pend_q)
            begin
                pend_q <= 1'b0;
                rvalid_out <= 1'b1;
                rdata_out <= store.exists(addr_q) ? store[addr_q]
                                                  : ~addr_q[WORD_W-1:0];
            end
            if (req_in.wr)
                store[req_in.addr] = req_in.wdata;
        end
    end
endmodule : rmw_mem_model
`default_nettype wire

/* xor_extract_unit_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module xor_extract_unit_bench;
    import xor_extract_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic issue_in = 1'b0;
    instr_t instr_in = '0;
    logic exec_mode_bit_in = 1'b0;
    logic slow = 1'b0;
    logic [WORD_W-1:0] rdata;
    logic rvalid;
    logic busy;
    mem_req_t req;
    logic [NREGS-1:0] ltag;
    logic [DATA_W-1:0] dval;
    int err_count = 0;
    int compares = 0;
    logic [DATA_W-1:0] dm [NREGS] = '{default: '0};
    logic [ADDR_W-1:0] rm [NREGS] = '{default: '0};
    logic [WORD_W-1:0] mm [logic [ADDR_W-1:0]];

    always #10 ref_clk_in = ~ref_clk_in;

    xor_extract_unit dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .issue_in(issue_in), .instr_in(instr_in),
        .exec_mode_bit_in(exec_mode_bit_in), .mem_rdata_in(rdata),
        .mem_rvalid_in(rvalid), .busy_out(busy), .mem_req_out(req),
        .limit_tag_bit_out(ltag), .dest_value_out(dval));
    rmw_mem_model mem (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .req_in(req), .slow_in(slow), .rdata_out(rdata),
        .rvalid_out(rvalid));

    // ----------------------------------------------------------------
    // reference model and checking
    // ----------------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        compares++;
        if (!ok)
        begin
            $display("CHECK FAILED at %0t: %s", $time, msg);
            err_count++;
        end
    endtask : check

    function automatic logic [DATA_W-1:0] sext(
        input logic [DATA_W-1:0] v, input int w, input int o);
        logic [DATA_W-1:0] r;
        r = v >> o;
        for (int b = 0; b < DATA_W; b++)
            if (b >= w) r[b] = (w == 0) ? 1'b0 : r[w-1];
        return r;
    endfunction : sext

    function automatic instr_t mk(input op_t op, input logic pf,
        input logic [3:0] ds, input logic [2:0] ss, input logic [2:0] fs,
        input logic [15:0] imm, input logic [15:0] off,
        input logic [5:0] w, input logic [5:0] o);
        return instr_t'{op, pf, ds, ss, fs, imm, off, w, o};
    endfunction : mk

    // model first, then issue; inj tries a second issue while busy
    task automatic run(input instr_t i, input logic inj);
        logic [3:0] di;
        logic [3:0] si;
        logic [DATA_W-1:0] ev;
        logic [ADDR_W-1:0] a;
        logic [ADDR_W-1:0] ra;
        logic [ADDR_W-1:0] wa;
        logic [WORD_W-1:0] ew;
        logic [WORD_W-1:0] wd;
        logic memop;
        int nrd;
        int nwr;
        int sh;
        di = {i.high_prefix, i.dest_sel[2:0]};
        si = {i.high_prefix, i.src_sel};
        sh = (i.op == OP_XOR_HIGH) ? HALF_HI : HALF_LO;
        memop = i.op inside {[OP_XOR_MEM_REG:OP_XOR_MEM_ABS]};
        nrd = 0;
        nwr = 0;
        a = SP_RESET;
        case (i.op)
            OP_XOR_REG: dm[di] = dm[si] ^ dm[di];
            OP_XOR_LOW, OP_XOR_HIGH:
                if (i.dest_sel[3]) rm[di] = rm[di] ^ (ADDR_W'(i.imm) << sh);
                else dm[di] = dm[di] ^ (DATA_W'(i.imm) << sh);
            OP_EXTRACT_IMM: dm[di] = sext(dm[{i.high_prefix, i.field_src}],
                i.width_imm, i.offset_imm);
            OP_EXTRACT_REG: dm[di] = sext(dm[{i.high_prefix, i.field_src}],
                dm[si][13:8], dm[si][5:0]);
            OP_XOR_MEM_REG: a = rm[di];
            OP_XOR_MEM_SPM: a = SP_RESET - ADDR_W'({i.offset[5:1], 1'b0});
            OP_XOR_MEM_SPP: a = SP_RESET + ADDR_W'(signed'(i.offset));
            default: a = ADDR_W'(i.offset);
        endcase
        ev = (i.dest_sel[3] && i.op inside {OP_XOR_LOW, OP_XOR_HIGH})
            ? DATA_W'(rm[di]) : dm[di];
        ew = mm.exists(a) ? mm[a] : ~a[WORD_W-1:0];
        ew = ew ^ i.imm;
        if (memop) mm[a] = ew;
        @(negedge ref_clk_in);
        issue_in = 1'b1;
        instr_in = i;
        @(negedge ref_clk_in);
        issue_in = inj;
        instr_in = mk(OP_XOR_LOW, 1'b0, 4'h0, 3'h0, 3'h0, 16'hffff,
            16'h0, 6'h0, 6'h0);
        // pulses stand one cycle, so one look per cycle catches each
        for (int k = 0; k < 40; k++)
        begin
            if (k == 0 && memop) check(busy === 1'b1, "busy during rmw");
            if (k == 1) issue_in = 1'b0;
            nrd += int'(req.rd === 1'b1);
            nwr += int'(req.wr === 1'b1);
            if (req.rd === 1'b1) ra = req.addr;
            if (req.wr === 1'b1) wa = req.addr;
            if (req.wr === 1'b1) wd = req.wdata;
            if (busy !== 1'b1 && k > 0) break;
            @(negedge ref_clk_in);
        end
        if (memop)
        begin
            check(nrd == 1 && nwr == 1, "access count");
            check(ra === a, "read address");
            check(wa === a && wd === ew, "write back");
        end
        else check(dval === ev, "reg result");
        check(ltag === '0, "limit tags");
    endtask : run

    task automatic conclude();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    initial
    begin
        #2_000_000;
        $display("CHECK FAILED at %0t: watchdog", $time);
        err_count++;
        conclude();
    end

    initial
    begin
        op_t op;
        logic pf;
        logic [3:0] ds;
        logic [2:0] ss;
        logic [2:0] fs;
        logic [15:0] imm;
        logic [15:0] off;
        logic [5:0] w;
        logic [5:0] o;
        void'($urandom(32'h837b));
        repeat (8) @(negedge ref_clk_in);
        check(busy === 1'b0 && dval === '0 && req === '0, "reset outputs");
        rst_n_in = 1'b1;
        repeat (3) @(negedge ref_clk_in);
        run(mk(OP_XOR_HIGH, 0, 4'h2, 0, 0, 16'h8665, 0, 0, 0), 0);
        run(mk(OP_XOR_LOW, 0, 4'h2, 0, 0, 16'h4321, 0, 0, 0), 0);
        run(mk(OP_EXTRACT_IMM, 0, 4'h4, 0, 2, 0, 0, 12, 14), 0);
        run(mk(OP_XOR_LOW, 0, 4'h1, 0, 0, 16'h2800, 0, 0, 0), 0);
        run(mk(OP_EXTRACT_REG, 0, 4'h5, 1, 2, 0, 0, 0, 0), 0);
        run(mk(OP_XOR_LOW, 1, 4'h2, 0, 0, 16'h9234, 0, 0, 0), 0);
        run(mk(OP_XOR_REG, 1, 4'h3, 2, 0, 0, 0, 0, 0), 0);
        run(mk(OP_XOR_HIGH, 1, 4'h9, 0, 0, 16'h0001, 0, 0, 0), 0);
        run(mk(OP_XOR_LOW, 0, 4'hc, 0, 0, 16'h0100, 0, 0, 0), 0);
        // every memory form, prompt then slow with a refused issue
        for (int s = 0; s < 2; s++)
        begin
            slow = s[0];
            exec_mode_bit_in = s[0];
            for (int f = 4; f < 8; f++)
                run(mk(op_t'(4'(f)), 0, 4'h4, 0, 0, 16'ha5a5, 16'hfff6,
                    0, 0), s[0]);
            run(mk(OP_XOR_LOW, 0, 4'h0, 0, 0, 16'h0, 0, 0, 0), 0);
        end
        // random mix; addresses kept even and fields within 40 bits
        for (int n = 0; n < 150; n++)
        begin
            op = op_t'(4'($urandom_range(1, 9)));
            pf = 1'($urandom);
            ds = 4'($urandom);
            ss = 3'($urandom);
            fs = 3'($urandom);
            imm = 16'($urandom) & {15'h7fff, ~ds[3]};
            off = 16'($urandom) & 16'hfffe;
            w = 6'($urandom_range(0, 40));
            o = 6'($urandom_range(0, 40 - int'(w)));
            slow = 1'($urandom);
            exec_mode_bit_in = 1'($urandom);
            if (op == OP_EXTRACT_REG)
                run(mk(OP_XOR_LOW, pf, {1'b0, ss}, 0, 0, dm[{pf, ss}][15:0]
                    ^ {2'b0, w, 2'b0, o}, 0, 0, 0), 0);
            run(mk(op, pf, ds, ss, fs, imm, off, w, o), 0);
        end
        conclude();
    end
endmodule : xor_extract_unit_bench
`default_nettype wire
